/* verilog/sdsr_pkg.sv */
// Package with status bank addresses, field layout and reset values
package sdsr_pkg;

   // ************************************************************
   // Register addresses and widths
   // ************************************************************
   localparam int unsigned        ADDR_W        = 8;
   localparam int unsigned        DATA_W        = 8;
   localparam logic [ADDR_W-1:0]  GENERAL_FAULT_STATUS_ADDR = 8'h04;
   localparam logic [ADDR_W-1:0]  X_BRIDGE_OVERCURRENT_STATUS_ADDR = 8'h05;
   localparam logic [ADDR_W-1:0]  Y_BRIDGE_OVERCURRENT_STATUS_ADDR = 8'h06;
   localparam logic [ADDR_W-1:0]  STEP_POSITION_STATUS_ADDR = 8'h07;

   // ************************************************************
   // Field positions and reset values
   // ************************************************************
   localparam int unsigned        CHECK_BIT     = 7;
   localparam int unsigned        TW_BIT        = 6;
   localparam int unsigned        PUMP_BIT      = 5;
   localparam int unsigned        OPEN_A_BIT    = 3;
   localparam int unsigned        OPEN_B_BIT    = 2;
   localparam int unsigned        OVL_MSB       = 6;
   localparam int unsigned        OVL_LSB       = 3;
   localparam int unsigned        TSD_BIT       = 2;
   localparam int unsigned        INDEX_W       = 7;
   localparam logic [DATA_W-1:0]  STATUS_RESET  = 8'h00;
   localparam logic [INDEX_W-1:0] INDEX_RESET   = 7'h00;
   localparam logic [3:0]         OVL_RESET     = 4'h0;
   localparam int unsigned        SYNC_STAGES   = 2;

   // Fault levels from the analog detectors
   typedef struct packed {
      logic thermal_warning_flag;
      logic pump_fault_flag;
      logic open_winding_a_flag;
      logic open_winding_b_flag;
      logic a_pos_high_side_overload;
      logic a_pos_low_side_overload;
      logic a_neg_high_side_overload;
      logic a_neg_low_side_overload;
      logic b_pos_high_side_overload;
      logic b_pos_low_side_overload;
      logic b_neg_high_side_overload;
      logic b_neg_low_side_overload;
      logic overheat_shutdown_flag;
   } sdsr_fault_t;

   // Read request from the serial frame logic
   typedef struct packed {
      logic              req;
      logic [ADDR_W-1:0] addr;
   } sdsr_read_t;

endpackage

/* verilog/sdsr_sync.sv */
// Two-stage synchroniser for asynchronous fault levels
`timescale 1ns/1ps
module sdsr_sync #(
   parameter int unsigned WIDTH = 1
) (
   input  wire logic             mclk,
   input  wire logic             resetn,
   input  wire logic             cen,
   input  wire logic [WIDTH-1:0] d,
   output logic      [WIDTH-1:0] q
);
   logic [WIDTH-1:0] meta;
   logic [WIDTH-1:0] next_meta;
   logic [WIDTH-1:0] next_q;

   // First stage feeds only the second
   always_comb
   begin
      next_meta = meta;
      next_q    = q;
      if (!resetn)
      begin
         next_meta = '0;
         next_q    = '0;
      end
      else if (cen)
      begin
         next_meta = d;
         next_q    = meta;
      end
   end

   always_ff @(posedge mclk)
   begin
      meta <= next_meta;
      q    <= next_q;
   end
endmodule // sdsr_sync

/* verilog/sdsr_status_bank.sv */
// Read-only fault and step position status bank of the stepper driver
// Notes on behaviour
// - Four read-only status registers; bit 7 of each holds a check bit.
// - Power-on or hard reset clears every fault status bit; step index follows its input.
// - Address 04h unlatched: pump fault at bit 5, thermal warning bit 6.
// - Address 04h: open winding A at bit 3, B at bit 2, unlatched.
// - Address 05h latched: A bridge overloads bits 6..3; bits 2..0 zero.
// - Address 06h latched: B bridge overloads bits 6..3, shutdown bit 2.
// - Address 07h unlatched: current 7-bit step index in bits 6..0.
`timescale 1ns/1ps
module sdsr_status_bank
   import sdsr_pkg::*;
(
   input  wire logic                          mclk,
   input  wire logic                          resetn,
   input  wire logic                          cen,
   input  wire sdsr_pkg::sdsr_fault_t         fault_in,
   input  wire logic [sdsr_pkg::INDEX_W-1:0]  microstep_index,
   input  wire sdsr_pkg::sdsr_read_t          rd,
   output logic                               rd_valid,
   output logic      [sdsr_pkg::DATA_W-1:0]   rd_data
);
   import sdsr_pkg::*;

   // ************************************************************
   // Fault level synchronisers
   // ************************************************************
   sdsr_fault_t fault_s;

   sdsr_sync #(
      .WIDTH ($bits(sdsr_fault_t))
   ) u_fault_sync (
      .mclk   (mclk),
      .resetn (resetn),
      .cen    (cen),
      .d      (fault_in),
      .q      (fault_s)
   );

   // ************************************************************
   // Latched overload flags
   // ************************************************************
   logic [3:0] a_latch;
   logic [4:0] b_latch;
   logic [3:0] next_a_latch;
   logic [4:0] next_b_latch;
   logic [3:0] a_now;
   logic [4:0] b_now;
   logic       a_clr;
   logic       b_clr;

   // Present fault levels in register order
   assign a_now = {fault_s.a_pos_high_side_overload,
                   fault_s.a_pos_low_side_overload,
                   fault_s.a_neg_high_side_overload,
                   fault_s.a_neg_low_side_overload};
   assign b_now = {fault_s.b_pos_high_side_overload,
                   fault_s.b_pos_low_side_overload,
                   fault_s.b_neg_high_side_overload,
                   fault_s.b_neg_low_side_overload,
                   fault_s.overheat_shutdown_flag};
   assign a_clr = rd.req && (rd.addr == X_BRIDGE_OVERCURRENT_STATUS_ADDR);
   assign b_clr = rd.req && (rd.addr == Y_BRIDGE_OVERCURRENT_STATUS_ADDR);

   // Sticky until read; a live fault wins over the read clear
   always_comb
   begin
      next_a_latch = a_latch;
      next_b_latch = b_latch;
      if (!resetn)
      begin
         next_a_latch = OVL_RESET;
         next_b_latch = {OVL_RESET, 1'b0};
      end
      else if (cen)
      begin
         next_a_latch = (a_latch & {4{~a_clr}}) | a_now;
         next_b_latch = (b_latch & {5{~b_clr}}) | b_now;
      end
   end

   always_ff @(posedge mclk)
   begin
      a_latch <= next_a_latch;
      b_latch <= next_b_latch;
   end

   // ************************************************************
   // Register images and read port
   // ************************************************************
   logic [DATA_W-1:0] img;
   logic [DATA_W-1:0] next_rd_data;
   logic              next_rd_valid;

   // Select image of addressed register below the check bit
   always_comb
   begin
      img = STATUS_RESET;
      case (rd.addr)
         GENERAL_FAULT_STATUS_ADDR:
         begin
            img[TW_BIT]     = fault_s.thermal_warning_flag;
            img[PUMP_BIT]   = fault_s.pump_fault_flag;
            img[OPEN_A_BIT] = fault_s.open_winding_a_flag;
            img[OPEN_B_BIT] = fault_s.open_winding_b_flag;
         end
         X_BRIDGE_OVERCURRENT_STATUS_ADDR:
            img[OVL_MSB:OVL_LSB] = a_latch;
         Y_BRIDGE_OVERCURRENT_STATUS_ADDR:
            img[OVL_MSB:TSD_BIT] = b_latch;
         STEP_POSITION_STATUS_ADDR:
            img[INDEX_W-1:0] = microstep_index;
         default:
            img = STATUS_RESET;
      endcase
      img[CHECK_BIT] = ~^img[CHECK_BIT-1:0];
   end

   // Answer one cycle after each request taken with cen high; unmapped reads give 80h (zero data, check bit set)
   always_comb
   begin
      next_rd_data  = rd_data;
      next_rd_valid = rd_valid;
      if (!resetn)
      begin
         next_rd_data  = STATUS_RESET;
         next_rd_valid = 1'b0;
      end
      else if (cen)
      begin
         next_rd_valid = rd.req;
         if (rd.req)
            next_rd_data = img;
      end
   end

   always_ff @(posedge mclk)
   begin
      rd_data  <= next_rd_data;
      rd_valid <= next_rd_valid;
   end

   // ************************************************************
   // Checks
   // ************************************************************
   logic mapped;
   assign mapped = (rd.addr >= GENERAL_FAULT_STATUS_ADDR) &&
                   (rd.addr <= STEP_POSITION_STATUS_ADDR);

   chk_reset_clear: assert property (@(posedge mclk)
      !resetn |=> (rd_data == 8'h00 && a_latch == 4'h0 &&
                   b_latch == 5'h00 && !rd_valid))
      else $error("status not cleared by reset");

   chk_odd_parity: assert property (@(posedge mclk) disable iff (!resetn)
      rd_valid |-> (^rd_data == 1'b1))
      else $error("check bit does not give odd parity");

   chk_answer_timing: assert property (@(posedge mclk)
      disable iff (!resetn)
      (cen && rd.req) |=> rd_valid)
      else $error("read not answered next cycle");

   chk_general_layout: assert property (@(posedge mclk)
      disable iff (!resetn)
      (cen && rd.req && rd.addr == GENERAL_FAULT_STATUS_ADDR) |=>
      rd_data[6:0] == {$past(fault_s.thermal_warning_flag),
                       $past(fault_s.pump_fault_flag), 1'b0,
                       $past(fault_s.open_winding_a_flag),
                       $past(fault_s.open_winding_b_flag), 2'b00})
      else $error("general status layout wrong");

   chk_a_bridge_read: assert property (@(posedge mclk)
      disable iff (!resetn)
      (cen && a_clr) |=>
      rd_data[6:0] == {$past(a_latch), 3'b000})
      else $error("A bridge register layout wrong");

   chk_b_bridge_read: assert property (@(posedge mclk)
      disable iff (!resetn)
      (cen && b_clr) |=> rd_data[6:0] == {$past(b_latch), 2'b00})
      else $error("B bridge register layout wrong");

   chk_index_read: assert property (@(posedge mclk)
      disable iff (!resetn)
      (cen && rd.req && rd.addr == STEP_POSITION_STATUS_ADDR) |=>
      rd_data[6:0] == $past(microstep_index))
      else $error("step index not reported");

   chk_latch_hold: assert property (@(posedge mclk)
      disable iff (!resetn)
      (cen && !a_clr) |=> ((a_latch & $past(a_latch)) == $past(a_latch)))
      else $error("latched flag dropped without read");

   chk_read_clear: assert property (@(posedge mclk)
      disable iff (!resetn)
      (cen && b_clr && b_now == 5'h00) |=> b_latch == 5'h00)
      else $error("latched flags not cleared by read");

   chk_unmapped_zero: assert property (@(posedge mclk)
      disable iff (!resetn)
      (cen && rd.req && !mapped) |=> rd_data == 8'h80)
      else $error("unmapped read not zero data");

   chk_cen_freeze: assert property (@(posedge mclk) disable iff (!resetn)
      !cen |=> ($stable(rd_data) && $stable(rd_valid) && $stable(a_latch)))
      else $error("state moved while clock enable low");

   chk_a_read_clear: assert property (@(posedge mclk)
      disable iff (!resetn)
      (cen && a_clr && a_now == 4'h0) |=> a_latch == 4'h0)
      else $error("latched A flags not cleared by read");

   chk_b_latch_hold: assert property (@(posedge mclk)
      disable iff (!resetn)
      (cen && !b_clr) |=> ((b_latch & $past(b_latch)) == $past(b_latch)))
      else $error("latched B flag dropped without read");

   chk_set_wins: assert property (@(posedge mclk)
      disable iff (!resetn)
      cen |=> ((b_latch & $past(b_now)) == $past(b_now)))
      else $error("live fault lost on read clear");

   chk_valid_pulse: assert property (@(posedge mclk)
      disable iff (!resetn)
      (cen && !rd.req) |=> !rd_valid)
      else $error("answer without a request");

endmodule // sdsr_status_bank

/* tb/sdsr_host_model.sv */
// Host side model that issues status reads into the bank
`timescale 1ns/1ps
module sdsr_host_model
   import sdsr_pkg::*;
(
   input  wire logic             mclk,
   output sdsr_pkg::sdsr_read_t  rd
);
   import sdsr_pkg::*;

   initial rd = '0;

   // One request per edge, back to back allowed
   task automatic issue(input logic [ADDR_W-1:0] a);
      @(posedge mclk);
      rd <= {1'b1, a};
   endtask

   // Drop the request; address no longer holds the old value
   task automatic idle();
      @(posedge mclk);
      rd <= {1'b0, ~rd.addr};
   endtask
endmodule // sdsr_host_model

/* tb/stepper_driver_status_registers_test.sv */
// Self-checking bench for the status register bank
`timescale 1ns/1ps
module stepper_driver_status_registers_test;
   import sdsr_pkg::*;

   logic                 mclk;
   logic                 resetn;
   logic                 cen;
   sdsr_fault_t          fault_in;
   logic [INDEX_W-1:0]   idx;
   sdsr_read_t           rd;
   logic                 rd_valid;
   logic [DATA_W-1:0]    rd_data;
   logic [DATA_W-1:0]    exp_q[$];
   logic [DATA_W-1:0]    want;
   int                   n_errors;
   int                   total_checks;
   int                   seed;
   logic [DATA_W-1:0]    bad_addr [4] = '{8'h00, 8'h03, 8'h08, 8'hFF};

   sdsr_status_bank dut (.mclk(mclk), .resetn(resetn), .cen(cen),
      .fault_in(fault_in), .microstep_index(idx), .rd(rd),
      .rd_valid(rd_valid), .rd_data(rd_data));
   sdsr_host_model u_host (.mclk(mclk), .rd(rd));

   // ************************************************************
   // Clock, compare and closing report
   // ************************************************************
   initial
   begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("FAIL t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask

   task automatic results();
      $display("checks=%0d errors=%0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // Word with odd check bit on top
   function automatic logic [7:0] p8(input logic [6:0] d);
      return {~^d, d};
   endfunction

   // Queue a read and its expected word
   task automatic rd_chk(input logic [7:0] a, input logic [6:0] d);
      u_host.issue(a);
      exp_q.push_back(p8(d));
   endtask

   // Any answer is matched to the oldest note; stray ones fail
   always @(posedge mclk)
      if (rd_valid === 1'b1)
      begin
         if (exp_q.size() == 0)
            check({7'h00, rd_valid}, 8'h00);
         else
         begin
            want = exp_q.pop_front();
            check(rd_data, want);
         end
      end

   // Wait for all answers under a bound
   task automatic drain();
      u_host.idle();
      for (int i = 0; i < 20 && exp_q.size() != 0; i++)
         @(posedge mclk);
      if (exp_q.size() != 0)
      begin
         n_errors++;
         results();
      end
   endtask

   // Fault held then removed; unlatched follow, latched hold till read
   task automatic fault_case(input sdsr_fault_t f);
      @(posedge mclk);
      fault_in <= f;
      idx <= 7'($random(seed));
      repeat (5) @(posedge mclk);
      rd_chk(8'h04, {f[12], f[11], 1'b0, f[10], f[9], 2'b00});
      rd_chk(8'h05, {f[8:5], 3'b000});
      rd_chk(8'h05, {f[8:5], 3'b000});
      rd_chk(8'h06, {f[4:1], f[0], 2'b00});
      rd_chk(8'h07, idx);
      drain();
      fault_in <= '0;
      repeat (5) @(posedge mclk);
      rd_chk(8'h04, 7'h00);
      rd_chk(8'h05, {f[8:5], 3'b000});
      rd_chk(8'h06, {f[4:1], f[0], 2'b00});
      rd_chk(8'h05, 7'h00);
      rd_chk(8'h06, 7'h00);
      drain();
   endtask

   // ************************************************************
   // Main sequence
   // ************************************************************
   initial
   begin
      seed = 32'h4bc38cb5;
      resetn = 1'b0;
      cen = 1'b1;
      fault_in = '0;
      idx = '0;
      repeat (10) @(posedge mclk);
      resetn <= 1'b1;
      for (int a = 4; a < 8; a++)
         rd_chk(a[7:0], 7'h00);
      foreach (bad_addr[i])
         rd_chk(bad_addr[i], 7'h00);
      drain();
      for (int b = 0; b < 13; b++)
         fault_case(sdsr_fault_t'(13'h1 << b));
      for (int k = 0; k < 6; k++)
         fault_case(sdsr_fault_t'(13'($random(seed))));
      // Requests while disabled must get no answer
      @(posedge mclk);
      cen <= 1'b0;
      u_host.issue(8'h04);
      u_host.idle();
      @(posedge mclk);
      cen <= 1'b1;
      repeat (3) @(posedge mclk);
      // Latched flag then mid-run reset clears it
      fault_in <= sdsr_fault_t'(13'h1FFF);
      repeat (5) @(posedge mclk);
      fault_in <= '0;
      idx <= '0;
      repeat (5) @(posedge mclk);
      resetn <= 1'b0;
      repeat (3) @(posedge mclk);
      resetn <= 1'b1;
      rd_chk(8'h05, 7'h00);
      rd_chk(8'h06, 7'h00);
      rd_chk(8'h04, 7'h00);
      drain();
      results();
   end

   // Watchdog on the whole run
   initial
   begin
      repeat (20000) @(posedge mclk);
      n_errors++;
      results();
   end
endmodule // stepper_driver_status_registers_test
